/* File: hw/clk_regs_defines.vh */
`ifndef CLK_REGS_DEFINES_VH
`define CLK_REGS_DEFINES_VH

// ==========================================================
// Register addresses
`define ADDR_LF_COMPONENT 12'h0F5
`define ADDR_LF_BYPASS 12'h0F6
`define ADDR_RSVD_TUNING 12'h190
`define ADDR_CH0_CTRL 12'h196
`define CH_STRIDE 12'h003
`define CH_OFS_CTRL 12'h000
`define CH_OFS_DIV_LO 12'h001
`define CH_OFS_DIV_HI 12'h002

// ==========================================================
// Reset values
`define RST_LF_COMPONENT 8'h00
`define RST_LF_BYPASS 8'h00
`define RST_RSVD_TUNING 8'h00
`define RST_CH_CTRL 8'h00
`define RST_CH_DIV_LO 8'h00
`define RST_CH_DIV_HI 8'h00
`define RST_READ 8'h00

// ==========================================================
// Loop filter fields
`define LF_POLE2_MSB 7
`define LF_POLE2_LSB 6
`define LF_ZERO_MSB 5
`define LF_ZERO_LSB 3
`define LF_CPOLE_MSB 2
`define LF_CPOLE_LSB 0
`define LF_BYPASS_BIT 0

// ==========================================================
// Channel control fields
`define CH_INVERT_BIT 7
`define CH_IGN_SYNC_BIT 6
`define CH_PDN_BIT 5
`define CH_LOWPWR_BIT 4
`define CH_MODE_MSB 3
`define CH_MODE_LSB 0
`define CH_PHASE_MSB 7
`define CH_PHASE_LSB 2
`define CH_DIVHI_MSB 1
`define CH_DIVHI_LSB 0

// ==========================================================
// Driver mode codes
`define MODE_TRISTATE 4'h0
`define MODE_DIFF_LAST 4'h5
`define MODE_CMOS_TT 4'h6
`define MODE_CMOS_TC 4'h7
`define MODE_CMOS_TZ 4'h8
`define MODE_CMOS_ZT 4'h9
`define MODE_CMOS_ZZ 4'hA
`define MODE_CMOS_CC 4'hB
`define MODE_CMOS_CT 4'hC
`define MODE_CMOS_CZ 4'hD
`define MODE_CMOS_ZC 4'hE
`define MODE_TRISTATE_ALT 4'hF

// ==========================================================
// First pole capacitor values in pF
`define CPOLE_PF_0 6'h00
`define CPOLE_PF_1 6'h08
`define CPOLE_PF_2 6'h10
`define CPOLE_PF_3 6'h18
`define CPOLE_PF_4 6'h18
`define CPOLE_PF_5 6'h20
`define CPOLE_PF_6 6'h28
`define CPOLE_PF_7 6'h30

`endif

/* File: hw/output_channel.v */
`timescale 1ns/10ps
`include "clk_regs_defines.vh"

module output_channel (
    input wire clk_sys, // System clock
    input wire rst_n, // Async reset, active low
    input wire [7:0] wdata, // Write data
    input wire wr_ctrl, // Write strobe, control register
    input wire wr_div_lo, // Write strobe, divider low byte
    input wire wr_div_hi, // Write strobe, phase and divider high
    input wire div_in_en, // Divider input clock enable
    input wire sync_req, // Synchronised chip sync level
    output reg [7:0] ctrl_reg, // Control register
    output reg [7:0] div_lo_reg, // Divider low register
    output reg [7:0] div_hi_reg, // Phase and divider high register
    output reg clk_out, // Driven divider output
    output reg out_p, // Plus pin level
    output reg out_n, // Minus pin level
    output reg oe_p, // Plus pin enable
    output reg oe_n, // Minus pin enable
    output reg diff_mode, // Differential driver selected
    output reg low_power, // Reduced power driver active
    output reg half_step // Extra half period of phase
);

    // ======================================================
    // Driver mode decode
    // Returns {oe_p, inv_p, oe_n, inv_n, diff}
    function [4:0] mode_decode;
        input [3:0] mode;
        begin
            case (mode)
                `MODE_TRISTATE: mode_decode = 5'h00;
                `MODE_CMOS_TT: mode_decode = 5'h14;
                `MODE_CMOS_TC: mode_decode = 5'h16;
                `MODE_CMOS_TZ: mode_decode = 5'h10;
                `MODE_CMOS_ZT: mode_decode = 5'h04;
                `MODE_CMOS_ZZ: mode_decode = 5'h00;
                `MODE_CMOS_CC: mode_decode = 5'h1E;
                `MODE_CMOS_CT: mode_decode = 5'h1C;
                `MODE_CMOS_CZ: mode_decode = 5'h18;
                `MODE_CMOS_ZC: mode_decode = 5'h06;
                `MODE_TRISTATE_ALT: mode_decode = 5'h00;
                default: mode_decode = 5'h17;
            endcase
        end
    endfunction

    wire [9:0] div_val = {div_hi_reg[`CH_DIVHI_MSB:`CH_DIVHI_LSB],
                          div_lo_reg};
    wire [5:0] phase = div_hi_reg[`CH_PHASE_MSB:`CH_PHASE_LSB];
    wire pdn = ctrl_reg[`CH_PDN_BIT];
    wire hold = sync_req & ~ctrl_reg[`CH_IGN_SYNC_BIT];
    wire [4:0] dec = mode_decode(ctrl_reg[`CH_MODE_MSB:`CH_MODE_LSB]);
    reg [9:0] cnt_reg;
    reg [9:0] cnt_next;
    reg level;

    // ======================================================
    // Registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `RST_CH_CTRL;
            div_lo_reg <= `RST_CH_DIV_LO;
            div_hi_reg <= `RST_CH_DIV_HI;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= wdata;
            if (wr_div_lo)
                div_lo_reg <= wdata;
            if (wr_div_hi)
                div_hi_reg <= wdata;
        end
    end

    // ======================================================
    // Divider, count runs 0..div_val so it divides by div_val+1
    always @* begin
        cnt_next = cnt_reg;
        if (hold)
            cnt_next = {5'h00, phase[5:1]};
        else if (div_in_en)
            cnt_next = (cnt_reg >= div_val) ? 10'h000 :
                       cnt_reg + 10'h001;
    end

    // Divide by one keeps the output high, or low with the invert bit set; no half-cycle clock here
    always @* begin
        level = (cnt_reg <= {1'b0, div_val[9:1]}) ^
                ctrl_reg[`CH_INVERT_BIT];
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 10'h000;
            clk_out <= 1'b0;
            out_p <= 1'b0;
            out_n <= 1'b0;
            oe_p <= 1'b0;
            oe_n <= 1'b0;
            diff_mode <= 1'b0;
            low_power <= 1'b0;
            half_step <= 1'b0;
        end else begin
            // Power-down freezes the divider and releases the pins
            if (!pdn)
                cnt_reg <= cnt_next;
            clk_out <= level & ~pdn;
            out_p <= level ^ dec[3];
            out_n <= level ^ dec[1];
            oe_p <= dec[4] & ~pdn;
            oe_n <= dec[2] & ~pdn;
            diff_mode <= dec[0] & ~pdn;
            // Only affects internal driver power, not swing
            low_power <= ctrl_reg[`CH_LOWPWR_BIT] & dec[0] & ~pdn;
            half_step <= phase[0];
        end
    end

endmodule // output_channel

/* File: hw/loop_filter_and_channel_ctrl_regs.v */
`timescale 1ns/10ps
`include "clk_regs_defines.vh"

// How it works
// - Loop filter bits 2:0 pick pole capacitor 0,8,16,24,24,32,40,48 pF.
// - Bit 0 at loop_filter_zero_bypass bypasses internal zero resistor; board adds one.
// - Reserved tuning register at 0x190 resets 0x00; software may write 0x20.
// - Six channels share one control layout; channel 0 starts at channel_output_control.
// - Control bit 6 set makes the channel ignore chip sync.
// - Control bit 4 picks low power driver, differential modes only.
// - Other codes give differential, paired CMOS, high-Z; 1111 tristate.
// - Channel divides by ten-bit field plus one, split across two registers.
// - Six-bit phase sets start offset after sync in half periods.
module loop_filter_and_channel_ctrl_regs #(
    parameter NUM_CH = 6
) (
    input wire clk_sys, // System clock, 125 MHz
    input wire rst_n, // Async reset, active low
    input wire [11:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    output reg [7:0] reg_rdata, // Read data, valid after reg_rd
    output reg reg_rvalid, // Read data valid pulse
    input wire sync_pin, // Chip sync level from pin
    input wire [NUM_CH-1:0] div_in_en, // Divider input enables
    output reg [1:0] pole2_res_code, // Pole 2 resistor code
    output reg [2:0] zero_res_code, // Zero resistor code
    output reg [2:0] first_pole_capacitor, // First pole capacitor code
    output reg [5:0] first_pole_cap_pf, // Capacitor value in pF
    output reg zero_res_bypass, // Internal zero resistor bypassed
    output wire [7:0] tuning_value, // Reserved tuning register
    output wire [NUM_CH-1:0] ch_clk, // Channel divider outputs
    output wire [NUM_CH-1:0] ch_out_p, // Plus pin levels
    output wire [NUM_CH-1:0] ch_out_n, // Minus pin levels
    output wire [NUM_CH-1:0] ch_oe_p, // Plus pin enables
    output wire [NUM_CH-1:0] ch_oe_n, // Minus pin enables
    output wire [NUM_CH-1:0] ch_diff, // Differential mode flags
    output wire [NUM_CH-1:0] ch_low_power, // Low power driver flags
    output wire [NUM_CH-1:0] ch_half_step // Half period phase flags
);

    // ======================================================
    // Capacitor value lookup
    // Codes 3 and 4 both give 24 pF
    function [5:0] cap_pf;
        input [2:0] code;
        begin
            case (code)
                3'h0: cap_pf = `CPOLE_PF_0;
                3'h1: cap_pf = `CPOLE_PF_1;
                3'h2: cap_pf = `CPOLE_PF_2;
                3'h3: cap_pf = `CPOLE_PF_3;
                3'h4: cap_pf = `CPOLE_PF_4;
                3'h5: cap_pf = `CPOLE_PF_5;
                3'h6: cap_pf = `CPOLE_PF_6;
                default: cap_pf = `CPOLE_PF_7;
            endcase
        end
    endfunction

    // Channel register address
    function [11:0] ch_addr;
        input integer ch;
        input [11:0] ofs;
        begin
            ch_addr = `ADDR_CH0_CTRL + ch[11:0] * `CH_STRIDE + ofs;
        end
    endfunction

    // ======================================================
    // Sync pin synchroniser
    // Only the second flop feeds logic; the first may go metastable
    reg sync_meta_reg;
    reg sync_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            sync_meta_reg <= sync_pin;
            sync_reg <= sync_meta_reg;
        end
    end

    // ======================================================
    // Address decode
    // One compare per loop filter and tuning register, shared by write and read paths
    wire hit_lf_comp;
    wire hit_lf_bypass;
    wire hit_tuning;

    assign hit_lf_comp = (reg_addr == `ADDR_LF_COMPONENT);
    assign hit_lf_bypass = (reg_addr == `ADDR_LF_BYPASS);
    assign hit_tuning = (reg_addr == `ADDR_RSVD_TUNING);

    // ======================================================
    // Loop filter and tuning registers
    reg [7:0] lf_comp_reg;
    reg [7:0] lf_bypass_reg;
    reg [7:0] tuning_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lf_comp_reg <= `RST_LF_COMPONENT;
            lf_bypass_reg <= `RST_LF_BYPASS;
            tuning_reg <= `RST_RSVD_TUNING;
        end else if (reg_wr) begin
            if (hit_lf_comp)
                lf_comp_reg <= reg_wdata;
            // Reserved upper bypass bits are not stored and read zero
            if (hit_lf_bypass)
                lf_bypass_reg <= {7'h00,
                                  reg_wdata[`LF_BYPASS_BIT]};
            if (hit_tuning)
                tuning_reg <= reg_wdata;
        end
    end

    assign tuning_value = tuning_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pole2_res_code <= 2'h0;
            zero_res_code <= 3'h0;
            first_pole_capacitor <= 3'h0;
            first_pole_cap_pf <= `CPOLE_PF_0;
            zero_res_bypass <= 1'b0;
        end else begin
            // Decoded outputs lag their register by one edge
            pole2_res_code <= lf_comp_reg[`LF_POLE2_MSB:`LF_POLE2_LSB];
            zero_res_code <= lf_comp_reg[`LF_ZERO_MSB:`LF_ZERO_LSB];
            first_pole_capacitor <=
                lf_comp_reg[`LF_CPOLE_MSB:`LF_CPOLE_LSB];
            first_pole_cap_pf <=
                cap_pf(lf_comp_reg[`LF_CPOLE_MSB:`LF_CPOLE_LSB]);
            // Board must then fit an external series resistor
            zero_res_bypass <= lf_bypass_reg[`LF_BYPASS_BIT];
        end
    end

    // ======================================================
    // Output channels
    wire [8*NUM_CH-1:0] ctrl_bus;
    wire [8*NUM_CH-1:0] div_lo_bus;
    wire [8*NUM_CH-1:0] div_hi_bus;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
            wire wr_ctrl_ch;
            wire wr_lo_ch;
            wire wr_hi_ch;

            // Divider halves land by separate writes, so no atomic update
            assign wr_ctrl_ch = reg_wr &
                (reg_addr == ch_addr(g, `CH_OFS_CTRL));
            assign wr_lo_ch = reg_wr &
                (reg_addr == ch_addr(g, `CH_OFS_DIV_LO));
            assign wr_hi_ch = reg_wr &
                (reg_addr == ch_addr(g, `CH_OFS_DIV_HI));

            output_channel i_output_channel (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .wdata(reg_wdata),
                .wr_ctrl(wr_ctrl_ch),
                .wr_div_lo(wr_lo_ch),
                .wr_div_hi(wr_hi_ch),
                .div_in_en(div_in_en[g]),
                .sync_req(sync_reg),
                .ctrl_reg(ctrl_bus[8*g+7:8*g]),
                .div_lo_reg(div_lo_bus[8*g+7:8*g]),
                .div_hi_reg(div_hi_bus[8*g+7:8*g]),
                .clk_out(ch_clk[g]),
                .out_p(ch_out_p[g]),
                .out_n(ch_out_n[g]),
                .oe_p(ch_oe_p[g]),
                .oe_n(ch_oe_n[g]),
                .diff_mode(ch_diff[g]),
                .low_power(ch_low_power[g]),
                .half_step(ch_half_step[g])
            );
        end
    endgenerate

    // ======================================================
    // Read mux; unmapped addresses read zero
    // Register addresses never overlap, so compare order does not matter
    reg [7:0] rd_next;
    integer i;

    always @* begin
        rd_next = `RST_READ;
        if (hit_lf_comp)
            rd_next = lf_comp_reg;
        if (hit_lf_bypass)
            rd_next = lf_bypass_reg;
        if (hit_tuning)
            rd_next = tuning_reg;
        for (i = 0; i < NUM_CH; i = i + 1) begin
            if (reg_addr == ch_addr(i, `CH_OFS_CTRL))
                rd_next = ctrl_bus[8*i +: 8];
            if (reg_addr == ch_addr(i, `CH_OFS_DIV_LO))
                rd_next = div_lo_bus[8*i +: 8];
            if (reg_addr == ch_addr(i, `CH_OFS_DIV_HI))
                rd_next = div_hi_bus[8*i +: 8];
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_READ;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            // Read data then holds until the next read
            if (reg_rd)
                reg_rdata <= rd_next;
        end
    end

endmodule // loop_filter_and_channel_ctrl_regs

/* File: tb/clk_regs_sva.sv */
`timescale 1ns/10ps
`include "clk_regs_defines.vh"

module clk_regs_sva #(
    parameter NUM_CH = 6
) (
    input wire clk_sys, // System clock
    input wire rst_n, // Async reset
    input wire [11:0] reg_addr, // Address
    input wire [7:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [7:0] reg_rdata, // Read data
    input wire reg_rvalid, // Read valid
    input wire [2:0] first_pole_capacitor, // Capacitor code
    input wire [5:0] first_pole_cap_pf, // Capacitor pF
    input wire zero_res_bypass, // Bypass flag
    input wire [7:0] tuning_value, // Tuning register
    input wire [NUM_CH-1:0] ch_clk, // Divider outputs
    input wire [NUM_CH-1:0] ch_oe_p, // Plus enables
    input wire [NUM_CH-1:0] ch_oe_n, // Minus enables
    input wire [NUM_CH-1:0] ch_diff, // Differential flags
    input wire [NUM_CH-1:0] ch_low_power // Low power flags
);
    // =====================================================
    // Helpers
    localparam [47:0] PF_TAB = {6'h30, 6'h28, 6'h20, 6'h18,
                                6'h18, 6'h10, 6'h08, 6'h00};
    wire [5:0] exp_pf = PF_TAB[first_pole_capacitor*6 +: 6];
    wire w_ctl = reg_wr && reg_addr == `ADDR_CH0_CTRL;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // =====================================================
    // Properties
    property p_pf_table;
        first_pole_cap_pf == exp_pf;
    endproperty
    a_pf_table: assert property (p_pf_table)
        else $error("capacitor pF does not match code");
    property p_cpole_wr;
        reg_wr && reg_addr == `ADDR_LF_COMPONENT |=> ##1
            first_pole_capacitor == $past(reg_wdata[2:0], 2);
    endproperty
    a_cpole_wr: assert property (p_cpole_wr)
        else $error("capacitor code not taken from write");
    property p_bypass;
        reg_wr && reg_addr == `ADDR_LF_BYPASS |=> ##1
            zero_res_bypass == $past(reg_wdata[0], 2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass flag not taken from write");
    property p_tuning_wr;
        reg_wr && reg_addr == `ADDR_RSVD_TUNING |=>
            tuning_value == $past(reg_wdata);
    endproperty
    a_tuning_wr: assert property (p_tuning_wr)
        else $error("tuning register not written");
    property p_tuning_rd;
        reg_rd && reg_addr == `ADDR_RSVD_TUNING |=>
            reg_rvalid && reg_rdata == $past(tuning_value);
    endproperty
    a_tuning_rd: assert property (p_tuning_rd)
        else $error("tuning read data wrong");
    property p_mode_off;
        w_ctl && reg_wdata[3:0] == 4'h0 |=> ##1 !ch_oe_p[0] && !ch_oe_n[0];
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("mode zero still drives");
    property p_mode_f;
        w_ctl && reg_wdata[3:0] == 4'hF |=> ##1 !ch_oe_p[0] && !ch_oe_n[0];
    endproperty
    a_mode_f: assert property (p_mode_f)
        else $error("mode fifteen still drives");
    property p_low_power;
        ch_low_power[0] |-> ch_diff[0];
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power outside differential mode");
    property p_pdn;
        w_ctl && reg_wdata[5] |=> ##1 (!ch_clk[0] && !ch_diff[0])[*2];
    endproperty
    a_pdn: assert property (p_pdn)
        else $error("powered down channel still active");

    c_cpole: cover property (reg_wr && reg_addr == `ADDR_LF_COMPONENT);
    c_read: cover property (reg_rvalid);
    c_pdn: cover property (w_ctl && reg_wdata[5]);
endmodule // clk_regs_sva

bind loop_filter_and_channel_ctrl_regs clk_regs_sva #(.NUM_CH(NUM_CH))
    i_clk_regs_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .first_pole_capacitor(first_pole_capacitor),
    .first_pole_cap_pf(first_pole_cap_pf),
    .zero_res_bypass(zero_res_bypass), .tuning_value(tuning_value),
    .ch_clk(ch_clk), .ch_oe_p(ch_oe_p), .ch_oe_n(ch_oe_n),
    .ch_diff(ch_diff), .ch_low_power(ch_low_power));

/* File: tb/loop_filter_and_channel_ctrl_regs_test.sv */
`timescale 1ns/10ps
`include "clk_regs_defines.vh"

module loop_filter_and_channel_ctrl_regs_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sync_pin = 1'b0;
    logic [5:0] div_in_en = 6'h00;
    wire [7:0] reg_rdata, tuning_value;
    wire reg_rvalid, zero_res_bypass;
    wire [1:0] pole2;
    wire [2:0] zcode, first_pole_capacitor;
    wire [5:0] first_pole_cap_pf, ch_clk, ch_oe_p, ch_oe_n, ch_diff;
    wire [5:0] ch_low_power, ch_half_step;
    wire [5:0] ch_out_p, ch_out_n;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [5:0] pf_tab [8] = '{6'h00, 6'h08, 6'h10, 6'h18,
                               6'h18, 6'h20, 6'h28, 6'h30};
    // Per driver mode at divider level 1: {oe_p, oe_n, p level, n level}
    logic [3:0] pin_tab [16] = '{4'h0, 4'hE, 4'hE, 4'hE, 4'hE, 4'hE,
                                 4'hF, 4'hE, 4'hA, 4'h5, 4'h0, 4'hC,
                                 4'hD, 4'h8, 4'h4, 4'h0};

    loop_filter_and_channel_ctrl_regs #(.NUM_CH(6))
        i_loop_filter_and_channel_ctrl_regs (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sync_pin(sync_pin), .div_in_en(div_in_en),
        .pole2_res_code(pole2), .zero_res_code(zcode),
        .first_pole_capacitor(first_pole_capacitor),
        .first_pole_cap_pf(first_pole_cap_pf),
        .zero_res_bypass(zero_res_bypass), .tuning_value(tuning_value),
        .ch_clk(ch_clk), .ch_out_p(ch_out_p), .ch_out_n(ch_out_n),
        .ch_oe_p(ch_oe_p),
        .ch_oe_n(ch_oe_n), .ch_diff(ch_diff),
        .ch_low_power(ch_low_power), .ch_half_step(ch_half_step));

    always #4 clk_sys = ~clk_sys;
    // Enable every other cycle, so divider periods span whole cycles
    always @(posedge clk_sys) div_in_en <= ~div_in_en;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            conclude;
        end
    end

    // =====================================================
    // Shared tasks
    task check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask

    task hi8(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (4) @(posedge clk_sys);
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            n = n + {7'h00, ch_clk[0]};
        end
        check(n, exp);
    endtask

    // =====================================================
    // Scenarios
    task t_reset;
        rd(`ADDR_LF_COMPONENT, 8'h00);
        rd(`ADDR_LF_BYPASS, 8'h00);
        rd(`ADDR_RSVD_TUNING, 8'h00);
        check(tuning_value, 8'h00);
        rd(12'h0FF, 8'h00);
    endtask

    task t_filter;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {c[1:0], c[2:0], c[2:0]};
            wr(`ADDR_LF_COMPONENT, d);
            check({5'h00, first_pole_capacitor}, c[7:0]);
            check({2'h0, first_pole_cap_pf}, {2'h0, pf_tab[c]});
            check({3'h0, pole2, zcode}, {3'h0, c[1:0], c[2:0]});
            rd(`ADDR_LF_COMPONENT, d);
        end
    endtask

    task t_bypass;
        wr(`ADDR_LF_BYPASS, 8'hFF);
        check({7'h00, zero_res_bypass}, 8'h01);
        rd(`ADDR_LF_BYPASS, 8'h01);
        wr(`ADDR_LF_BYPASS, 8'h00);
        check({7'h00, zero_res_bypass}, 8'h00);
    endtask

    task t_tuning;
        wr(`ADDR_RSVD_TUNING, 8'h20);
        rd(`ADDR_RSVD_TUNING, 8'h20);
        check(tuning_value, 8'h20);
    endtask

    task t_chan;
        for (int n = 0; n < 6; n++) begin
            wr(12'h196 + 12'(3 * n), 8'(8'h50 + n));
        end
        for (int n = 0; n < 6; n++) begin
            rd(12'h196 + 12'(3 * n), 8'(8'h50 + n));
        end
        rd(12'h1A8, 8'h00);
    endtask

    task t_modes;
        logic dif, on;
        logic [3:0] pins;
        for (int m = 0; m < 16; m++) begin
            dif = m >= 1 && m <= 5;
            on = m != 0 && m != 10 && m != 15;
            wr(`ADDR_CH0_CTRL, 8'h10 | m[7:0]);
            pins = {ch_oe_p[0], ch_oe_n[0], ch_out_p[0] & ch_oe_p[0],
                    ch_out_n[0] & ch_oe_n[0]};
            check({4'h0, pins}, {4'h0, pin_tab[m]});
            check({7'h00, ch_oe_p[0] | ch_oe_n[0]}, {7'h00, on});
            check({7'h00, ch_diff[0]}, {7'h00, dif});
            check({7'h00, ch_low_power[0]}, {7'h00, dif});
        end
        wr(`ADDR_CH0_CTRL, 8'h31);
        check({6'h00, ch_oe_p[0], ch_oe_n[0]}, 8'h00);
        check({6'h00, ch_diff[0], ch_clk[0]}, 8'h00);
    endtask

    task t_div;
        wr(12'h197, 8'h00);
        wr(12'h198, 8'h04);
        check({7'h00, ch_half_step[0]}, 8'h01);
        wr(`ADDR_CH0_CTRL, 8'h01);
        hi8(8'h08);
        wr(12'h197, 8'h01);
        hi8(8'h04);
        @(posedge clk_sys);
        sync_pin <= 1'b1;
        hi8(8'h08);
        wr(`ADDR_CH0_CTRL, 8'h41);
        hi8(8'h04);
        @(posedge clk_sys);
        sync_pin <= 1'b0;
    endtask

    task conclude;
        $display("Errors %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_filter;
        t_bypass;
        t_tuning;
        t_chan;
        t_modes;
        t_div;
        conclude;
    end
endmodule // loop_filter_and_channel_ctrl_regs_test
